/* verilog/sfcalu_top.sv */
`timescale 1ns/100ps
// Overview of operation
// - Immediate form writes inverted source plus one plus sign-extended 16-bit immediate.
// - Immediate form has opcode 08 in top six bits, immediate in bits 16-31.
// - Immediate of minus one yields the plain inverse of the source.
// - Immediate form never touches condition field 0, always updates carry.
// - Minus-one form writes inverted source plus carry plus all-ones.
// - Minus-one form is opcode 31, extended 232; bit 21 overflow enable, 31 record.
// - Zero form writes inverted source plus carry plus zero.
// - Zero form is opcode 31, extended 200, same enable and record bits.
// - Both extended forms always update the carry flag.
// - Overflow enable set updates overflow and summary overflow, else only carry.
// - Record bit set updates sign bits and summary copy in condition field 0.
// - Target index from bits 6-10, source index from bits 11-15.
// - Old and new names of each form share encoding and behaviour.

module sfcalu_top
(
  input  wire logic                            ref_clk_in,
  input  wire logic                            nrst_in,
  input  wire logic [sfcalu_pkg::ADDR_W-1:0]   s_axi_awaddr_in,
  input  wire logic                            s_axi_awvalid_in,
  output logic                                 s_axi_awready_out,
  input  wire logic [31:0]                     s_axi_wdata_in,
  input  wire logic [3:0]                      s_axi_wstrb_in,
  input  wire logic                            s_axi_wvalid_in,
  output logic                                 s_axi_wready_out,
  output logic [1:0]                           s_axi_bresp_out,
  output logic                                 s_axi_bvalid_out,
  input  wire logic                            s_axi_bready_in,
  input  wire logic [sfcalu_pkg::ADDR_W-1:0]   s_axi_araddr_in,
  input  wire logic                            s_axi_arvalid_in,
  output logic                                 s_axi_arready_out,
  output logic [31:0]                          s_axi_rdata_out,
  output logic [1:0]                           s_axi_rresp_out,
  output logic                                 s_axi_rvalid_out,
  input  wire logic                            s_axi_rready_in,
  output logic [31:0]                          result_out,
  output logic [4:0]                           target_reg_index_out,
  output sfcalu_pkg::sfcalu_xer_s              xer_out,
  output sfcalu_pkg::sfcalu_cr0_s              cr0_out,
  output logic                                 done_out,
  output logic                                 irq_out
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction

  function automatic logic [5:0] word_of(input logic [5:0] a);
    return {a[5:2], 2'b00};
  endfunction

  // Alias mnemonics need no special case: only the encoding is seen here.
  function automatic sfcalu_pkg::sfcalu_kind_e kind_of(input logic [31:0] i);
    sfcalu_pkg::sfcalu_kind_e k;
    k = sfcalu_pkg::KIND_BAD;
    if (i[sfcalu_pkg::OPC_LO +: 6] == sfcalu_pkg::OP_IMM)
      k = sfcalu_pkg::KIND_IMM;
    else if (i[sfcalu_pkg::OPC_LO +: 6] == sfcalu_pkg::OP_EXT)
    begin
      if (i[sfcalu_pkg::XO_LO +: 9] == sfcalu_pkg::XO_ME)
        k = sfcalu_pkg::KIND_ME;
      else if (i[sfcalu_pkg::XO_LO +: 9] == sfcalu_pkg::XO_ZE)
        k = sfcalu_pkg::KIND_ZE;
    end
    return k;
  endfunction

  // ---------------------------------------------------------------
  // State and bus decode
  // ---------------------------------------------------------------
  sfcalu_pkg::sfcalu_state_s s_q;
  sfcalu_pkg::sfcalu_state_s s_d;

  logic                     wr_fire;
  logic [5:0]               wr_addr;
  logic                     ex_fire;
  logic [31:0]              ins;
  sfcalu_pkg::sfcalu_kind_e kind;
  logic                     is_ext;
  logic                     oe;
  logic                     record_bit;
  logic [4:0]               d_tgt;
  logic [4:0]               d_src;
  logic [31:0]              k_add;
  logic                     cin;
  logic [32:0]              sum;
  logic                     ovf;
  logic                     rd_fire;
  logic [5:0]               rd_addr;

  // A write is carried out only once both halves are held and the
  // previous response has gone, so aw and w may come in either order.
  assign wr_fire = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
  assign wr_addr = word_of(s_q.aw_addr);
  assign ex_fire = wr_fire && (wr_addr == sfcalu_pkg::OFS_INSTR);
  assign ins     = merge(s_q.instr, s_q.w_data, s_q.w_strb);
  assign kind    = kind_of(ins);
  assign is_ext  = (kind == sfcalu_pkg::KIND_ME) || (kind == sfcalu_pkg::KIND_ZE);
  assign oe      = ins[sfcalu_pkg::OE_BIT];
  assign record_bit = ins[sfcalu_pkg::RECORD_BIT];
  assign d_tgt   = ins[sfcalu_pkg::TGT_LO +: 5];
  assign d_src   = ins[sfcalu_pkg::SRC_LO +: 5];
  assign rd_fire = s_axi_arvalid_in && !s_q.rvalid;
  assign rd_addr = word_of(s_axi_araddr_in);

  // ---------------------------------------------------------------
  // Adder: inverted source plus a per-form constant plus carry in
  // ---------------------------------------------------------------
  always_comb
  begin
    case (kind)
      sfcalu_pkg::KIND_IMM:
      begin
        k_add = {{16{ins[15]}}, ins[15:0]};
        cin   = 1'b1;
      end
      sfcalu_pkg::KIND_ME:
      begin
        k_add = sfcalu_pkg::K_ONES;
        cin   = s_q.xer.carry_flag;
      end
      sfcalu_pkg::KIND_ZE:
      begin
        k_add = sfcalu_pkg::K_ZERO;
        cin   = s_q.xer.carry_flag;
      end
      default:
      begin
        k_add = sfcalu_pkg::K_ZERO;
        cin   = 1'b0;
      end
    endcase
  end

  assign sum = {1'b0, ~s_q.src} + {1'b0, k_add} + {32'h0, cin};
  assign ovf = (~s_q.src[31] == k_add[31]) && (sum[31] != k_add[31]);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (s_q.bvalid && s_axi_bready_in)
      s_d.bvalid = 1'b0;
    if (s_q.rvalid && s_axi_rready_in)
      s_d.rvalid = 1'b0;
    if (s_axi_awvalid_in && !s_q.aw_hold)
    begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !s_q.w_hold)
    begin
      s_d.w_hold = 1'b1;
      s_d.w_data = s_axi_wdata_in;
      s_d.w_strb = s_axi_wstrb_in;
    end
    if (wr_fire)
    begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = sfcalu_pkg::RESP_OKAY;
      case (wr_addr)
        sfcalu_pkg::OFS_SRC:     s_d.src = merge(s_q.src, s_q.w_data, s_q.w_strb);
        sfcalu_pkg::OFS_INSTR:   s_d.instr = ins;
        sfcalu_pkg::OFS_XER:     s_d.xer = 3'(merge(32'(s_q.xer), s_q.w_data, s_q.w_strb));
        sfcalu_pkg::OFS_CR0:     s_d.cr0 = 4'(merge(32'(s_q.cr0), s_q.w_data, s_q.w_strb));
        sfcalu_pkg::OFS_IRQ_CLR: s_d.irq_stat = s_q.irq_stat & ~s_q.w_data[2:0];
        sfcalu_pkg::OFS_IRQ_EN:  s_d.irq_en = 3'(merge(32'(s_q.irq_en), s_q.w_data, s_q.w_strb));
        sfcalu_pkg::OFS_RESULT,
        sfcalu_pkg::OFS_INDEX,
        sfcalu_pkg::OFS_IRQ_ST:  s_d.bresp = sfcalu_pkg::RESP_OKAY;
        default:                 s_d.bresp = sfcalu_pkg::RESP_SLVERR;
      endcase
    end

    // Event bits are set after the clear so that a set always wins.
    if (ex_fire)
    begin
      if (kind == sfcalu_pkg::KIND_BAD)
        s_d.irq_stat[sfcalu_pkg::IRQ_ILL] = 1'b1;
      else
      begin
        s_d.done   = 1'b1;
        s_d.irq_stat[sfcalu_pkg::IRQ_DONE] = 1'b1;
        s_d.result = sum[31:0];
        s_d.tgt    = d_tgt;
        s_d.srci   = d_src;
        s_d.xer.carry_flag = sum[32];
        if (is_ext && oe)
        begin
          s_d.xer.overflow_flag = ovf;
          s_d.xer.so = s_q.xer.so | ovf;
          if (ovf)
            s_d.irq_stat[sfcalu_pkg::IRQ_OVF] = 1'b1;
        end
        // The immediate form has no record bit, so its low bit is data.
        if (is_ext && record_bit)
        begin
          s_d.cr0.negative_result_bit = sum[31];
          s_d.cr0.positive_result_bit = !sum[31] && (sum[31:0] != 32'h0);
          s_d.cr0.zero_result_bit = (sum[31:0] == 32'h0);
          s_d.cr0.so = s_d.xer.so;
        end
      end
    end

    if (rd_fire)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = sfcalu_pkg::RESP_OKAY;
      case (rd_addr)
        sfcalu_pkg::OFS_SRC:     s_d.rdata = s_q.src;
        sfcalu_pkg::OFS_INSTR:   s_d.rdata = s_q.instr;
        sfcalu_pkg::OFS_RESULT:  s_d.rdata = s_q.result;
        sfcalu_pkg::OFS_INDEX:   s_d.rdata = {19'h0, s_q.srci, 3'h0, s_q.tgt};
        sfcalu_pkg::OFS_XER:     s_d.rdata = {29'h0, s_q.xer};
        sfcalu_pkg::OFS_CR0:     s_d.rdata = {28'h0, s_q.cr0};
        sfcalu_pkg::OFS_IRQ_ST:  s_d.rdata = {29'h0, s_q.irq_stat};
        sfcalu_pkg::OFS_IRQ_CLR: s_d.rdata = 32'h0;
        sfcalu_pkg::OFS_IRQ_EN:  s_d.rdata = {29'h0, s_q.irq_en};
        default:
        begin
          s_d.rdata = 32'h0;
          s_d.rresp = sfcalu_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      s_q <= sfcalu_pkg::STATE_RST;
    else
      s_q <= s_d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready_out    = !s_q.aw_hold;
  assign s_axi_wready_out     = !s_q.w_hold;
  assign s_axi_bvalid_out     = s_q.bvalid;
  assign s_axi_bresp_out      = s_q.bresp;
  assign s_axi_arready_out    = !s_q.rvalid;
  assign s_axi_rvalid_out     = s_q.rvalid;
  assign s_axi_rdata_out      = s_q.rdata;
  assign s_axi_rresp_out      = s_q.rresp;
  assign result_out           = s_q.result;
  assign target_reg_index_out = s_q.tgt;
  assign xer_out              = s_q.xer;
  assign cr0_out              = s_q.cr0;
  assign done_out             = s_q.done;
  assign irq_out              = |(s_q.irq_stat & s_q.irq_en);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Reference values are formed apart from the shared adder so that a
  // slip in the operand select or carry path shows up here.
  logic [31:0] h_imm_exp;
  logic [31:0] h_me_exp;
  logic [31:0] h_ze_exp;
  logic        h_ext_c;
  logic        h_imm_c;
  logic [32:0] h_imm_w;

  assign h_imm_exp = ~s_q.src + {{16{ins[15]}}, ins[15:0]} + 32'h1;
  assign h_me_exp  = ~s_q.src - 32'h1 + {31'h0, s_q.xer.carry_flag};
  assign h_ze_exp  = ~s_q.src + {31'h0, s_q.xer.carry_flag};
  assign h_imm_w   = {1'b0, {{16{ins[15]}}, ins[15:0]}} - {1'b0, s_q.src};
  assign h_imm_c   = !h_imm_w[32];
  assign h_ext_c   = (kind == sfcalu_pkg::KIND_ME)
                     ? !((s_q.src == 32'hffffffff) && !s_q.xer.carry_flag)
                     : ((s_q.src == 32'h0) && s_q.xer.carry_flag);

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);

  property p_imm_sum;
    ex_fire && (kind == sfcalu_pkg::KIND_IMM) |=> s_q.result == $past(h_imm_exp);
  endproperty
  a_imm_sum: assert property (p_imm_sum) else $error("immediate form result wrong");
  property p_imm_decode;
    ex_fire && (ins[31:26] == 6'h08) |=> s_q.done ##1 !s_q.done;
  endproperty
  a_imm_decode: assert property (p_imm_decode) else $error("opcode 08 not run once");
  property p_imm_minus1;
    ex_fire && (kind == sfcalu_pkg::KIND_IMM) && (ins[15:0] == 16'hffff)
      |=> s_q.result == ~$past(s_q.src);
  endproperty
  a_imm_minus1: assert property (p_imm_minus1) else $error("minus one not inverse");
  property p_imm_flags;
    ex_fire && (kind == sfcalu_pkg::KIND_IMM)
      |=> $stable(s_q.cr0) && (s_q.xer.carry_flag == $past(h_imm_c));
  endproperty
  a_imm_flags: assert property (p_imm_flags) else $error("immediate form flags wrong");
  property p_me_sum;
    ex_fire && (kind == sfcalu_pkg::KIND_ME) |=> s_q.result == $past(h_me_exp);
  endproperty
  a_me_sum: assert property (p_me_sum) else $error("minus-one form result wrong");
  property p_me_decode;
    ex_fire && (ins[31:26] == 6'h1f) && (ins[9:1] == 9'd232) |=> s_q.done;
  endproperty
  a_me_decode: assert property (p_me_decode) else $error("extended 232 not run");
  property p_ze_sum;
    ex_fire && (kind == sfcalu_pkg::KIND_ZE) |=> s_q.result == $past(h_ze_exp);
  endproperty
  a_ze_sum: assert property (p_ze_sum) else $error("zero form result wrong");
  property p_ze_decode;
    ex_fire && (ins[31:26] == 6'h1f) && (ins[9:1] == 9'd200) |=> s_q.done;
  endproperty
  a_ze_decode: assert property (p_ze_decode) else $error("extended 200 not run");
  property p_ext_carry;
    ex_fire && is_ext |=> s_q.xer.carry_flag == $past(h_ext_c);
  endproperty
  a_ext_carry: assert property (p_ext_carry) else $error("extended carry wrong");
  property p_ov_gate;
    ex_fire && is_ext && !oe |=> $stable(s_q.xer.overflow_flag) && $stable(s_q.xer.so);
  endproperty
  a_ov_gate: assert property (p_ov_gate) else $error("overflow moved with enable clear");
  property p_record_gate;
    ex_fire && !(is_ext && record_bit) |=> $stable(s_q.cr0);
  endproperty
  a_record_gate: assert property (p_record_gate) else $error("condition field moved");
  property p_index;
    ex_fire && (kind != sfcalu_pkg::KIND_BAD)
      |=> (s_q.tgt == $past(d_tgt)) && (s_q.srci == $past(d_src));
  endproperty
  a_index: assert property (p_index) else $error("register index wrong");
  property p_so_sticky;
    ex_fire && is_ext && oe
      |=> (s_q.xer.so == ($past(s_q.xer.so) | s_q.xer.overflow_flag))
          && (s_q.xer.overflow_flag == $past(ovf));
  endproperty
  a_so_sticky: assert property (p_so_sticky) else $error("summary overflow not sticky");
  property p_cr0_sign;
    ex_fire && is_ext && record_bit
      |=> $onehot({s_q.cr0.negative_result_bit, s_q.cr0.positive_result_bit,
                   s_q.cr0.zero_result_bit})
          && (s_q.cr0.negative_result_bit == s_q.result[31]) && (s_q.cr0.so == s_q.xer.so);
  endproperty
  a_cr0_sign: assert property (p_cr0_sign) else $error("condition bits wrong");

  c_imm: cover property (ex_fire && (kind == sfcalu_pkg::KIND_IMM));
  c_me_oe_record: cover property (ex_fire && (kind == sfcalu_pkg::KIND_ME) && oe && record_bit);
  c_ze_ovf: cover property (ex_fire && (kind == sfcalu_pkg::KIND_ZE) && oe && ovf);
  c_illegal: cover property (ex_fire && (kind == sfcalu_pkg::KIND_BAD));

endmodule

/* pkg/sfcalu_pkg.sv */
package sfcalu_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W      = 6;
  localparam logic [5:0]  OFS_SRC     = 6'h00;
  localparam logic [5:0]  OFS_INSTR   = 6'h04;
  localparam logic [5:0]  OFS_RESULT  = 6'h08;
  localparam logic [5:0]  OFS_INDEX   = 6'h0c;
  localparam logic [5:0]  OFS_XER     = 6'h10;
  localparam logic [5:0]  OFS_CR0     = 6'h14;
  localparam logic [5:0]  OFS_IRQ_ST  = 6'h18;
  localparam logic [5:0]  OFS_IRQ_CLR = 6'h1c;
  localparam logic [5:0]  OFS_IRQ_EN  = 6'h20;

  // ---------------------------------------------------------------
  // Instruction fields (bit 0 of the word is the least significant)
  // ---------------------------------------------------------------
  localparam int unsigned OPC_LO  = 26;
  localparam int unsigned TGT_LO  = 21;
  localparam int unsigned SRC_LO  = 16;
  localparam int unsigned OE_BIT  = 10;
  localparam int unsigned XO_LO   = 1;
  localparam int unsigned RECORD_BIT = 0;
  localparam logic [5:0]  OP_IMM  = 6'h08;
  localparam logic [5:0]  OP_EXT  = 6'h1f;
  localparam logic [8:0]  XO_ME   = 9'he8;
  localparam logic [8:0]  XO_ZE   = 9'hc8;
  localparam logic [31:0] K_ONES  = 32'hffffffff;
  localparam logic [31:0] K_ZERO  = 32'h00000000;

  // ---------------------------------------------------------------
  // Index register and interrupt bit positions
  // ---------------------------------------------------------------
  localparam int unsigned IDX_SRC_LO = 8;
  localparam int unsigned IRQ_DONE   = 0;
  localparam int unsigned IRQ_OVF    = 1;
  localparam int unsigned IRQ_ILL    = 2;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    KIND_IMM = 2'b00,
    KIND_ME  = 2'b01,
    KIND_ZE  = 2'b10,
    KIND_BAD = 2'b11
  } sfcalu_kind_e;

  typedef struct packed {
    logic so;
    logic overflow_flag;
    logic carry_flag;
  } sfcalu_xer_s;

  typedef struct packed {
    logic negative_result_bit;
    logic positive_result_bit;
    logic zero_result_bit;
    logic so;
  } sfcalu_cr0_s;

  typedef struct packed {
    logic        aw_hold;
    logic [5:0]  aw_addr;
    logic        w_hold;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] src;
    logic [31:0] instr;
    logic [31:0] result;
    logic [4:0]  tgt;
    logic [4:0]  srci;
    sfcalu_xer_s xer;
    sfcalu_cr0_s cr0;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_en;
    logic        done;
  } sfcalu_state_s;

  localparam sfcalu_state_s STATE_RST = '0;

endpackage

/* testbench/sfcalu_host.sv */
`timescale 1ns/100ps
module sfcalu_host
(
  input  wire logic        ref_clk_in,
  output logic [5:0]       awaddr_out,
  output logic             awvalid_out,
  input  wire logic        awready_in,
  output logic [31:0]      wdata_out,
  output logic [3:0]       wstrb_out,
  output logic             wvalid_out,
  input  wire logic        wready_in,
  input  wire logic [1:0]  bresp_in,
  input  wire logic        bvalid_in,
  output logic             bready_out,
  output logic [5:0]       araddr_out,
  output logic             arvalid_out,
  input  wire logic        arready_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp_in,
  input  wire logic        rvalid_in,
  output logic             rready_out
);
  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  // Response code 3 never comes from the slave, so it marks a wait that ran out.
  initial
  begin
    {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out} = '0;
    {bready_out, araddr_out, arvalid_out, rready_out} = '0;
  end

  task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    r = 2'h3;
    @(posedge ref_clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    wstrb_out <= 4'hf;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge ref_clk_in);
      if (awready_in) awvalid_out <= 1'b0;
      if (wready_in) wvalid_out <= 1'b0;
      if (bvalid_in)
      begin
        r = bresp_in;
        bready_out <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    r = 2'h3;
    d = '0;
    @(posedge ref_clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge ref_clk_in);
      if (arready_in) arvalid_out <= 1'b0;
      if (rvalid_in)
      begin
        d = rdata_in;
        r = rresp_in;
        rready_out <= 1'b0;
        break;
      end
    end
  endtask
endmodule

/* testbench/sfcalu_top_tb.sv */
`timescale 1ns/100ps
module sfcalu_top_tb;
  typedef struct packed {
    logic [1:0]  k;
    logic [1:0]  orc;
    logic [15:0] imm;
    logic [31:0] src;
    logic [2:0]  x0;
    logic [31:0] res;
    logic [2:0]  x;
    logic [3:0]  c;
  } sfcalu_row_s;

  logic ref_clk_in, nrst_in, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, done_out, irq_out;
  logic [5:0]              awa, ara;
  logic [31:0]             wd, rd_d, result_out, ins;
  logic [3:0]              ws;
  logic [1:0]              bresp, rresp;
  logic [4:0]              target_reg_index_out, t, s;
  sfcalu_pkg::sfcalu_xer_s xer_out;
  sfcalu_pkg::sfcalu_cr0_s cr0_out;
  sfcalu_row_s             rw;
  int                      i, fails = 0, compares = 0, dones = 0;
  sfcalu_row_s rows [0:9] = '{
    '{2'h0, 2'h0, 16'h7000, 32'h90003000, 3'h3, 32'h70004000, 3'h2, 4'ha},
    '{2'h0, 2'h0, 16'hffff, 32'h12345678, 3'h2, 32'hedcba987, 3'h3, 4'ha},
    '{2'h1, 2'h0, 16'h0, 32'h90003000, 3'h0, 32'h6fffcffe, 3'h1, 4'ha},
    '{2'h1, 2'h1, 16'h0, 32'hb0043000, 3'h4, 32'h4ffbcffe, 3'h5, 4'h5},
    '{2'h1, 2'h2, 16'h0, 32'hefffffff, 3'h3, 32'h10000000, 3'h1, 4'ha},
    '{2'h1, 2'h3, 16'h0, 32'h7fffffff, 3'h0, 32'h7fffffff, 3'h7, 4'h5},
    '{2'h2, 2'h0, 16'h0, 32'h90003000, 3'h1, 32'h6fffd000, 3'h0, 4'ha},
    '{2'h2, 2'h3, 16'h0, 32'hffffffff, 3'h4, 32'h00000000, 3'h4, 4'h3},
    '{2'h2, 2'h1, 16'h0, 32'h00000000, 3'h1, 32'h00000000, 3'h1, 4'h2},
    '{2'h2, 2'h3, 16'h0, 32'h80000000, 3'h1, 32'h80000000, 3'h6, 4'h9}};

  sfcalu_top sfcalu_top_i (.ref_clk_in, .nrst_in, .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr_rdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(br), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rd_d), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .result_out, .target_reg_index_out,
    .xer_out, .cr0_out, .done_out, .irq_out);

  sfcalu_host sfcalu_host_i (.ref_clk_in, .awaddr_out(awa), .awvalid_out(awv), .awready_in(awr),
    .wdata_out(wd), .wstrb_out(ws), .wvalid_out(wv), .wready_in(wr_rdy), .bresp_in(bresp),
    .bvalid_in(bv), .bready_out(br), .araddr_out(ara), .arvalid_out(arv), .arready_in(arr),
    .rdata_in(rd_d), .rresp_in(rresp), .rvalid_in(rv), .rready_out(rr));

  // Pulses are counted as they pass, so a stuck or missing pulse shows in the total.
  always @(posedge ref_clk_in)
    if (done_out) dones <= dones + 1;

  // ---------------------------------------------------------------
  // Checking and bus wrappers
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    sfcalu_host_i.wr(a, d, r);
    chk({30'h0, r}, {30'h0, e});
    if (r === 2'h3) final_report();
  endtask

  task automatic br_(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    sfcalu_host_i.rd(a, d, r);
    chk({30'h0, r}, {30'h0, er});
    if (r === 2'h3) final_report();
    chk(d, e);
  endtask

  initial
  begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  initial
  begin
    nrst_in = 1'b0;
    repeat (20) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    // Unused bits of the extended forms are set to ones to show they are ignored.
    for (i = 0; i < 10; i++)
    begin
      rw = rows[i];
      t = 5'(i + 3);
      s = 5'(30 - i);
      ins = (rw.k == 2'h0) ? {6'h08, t, s, rw.imm} : {6'h1f, t, s, 5'h1f, rw.orc[1],
            (rw.k == 2'h1) ? 9'he8 : 9'hc8, rw.orc[0]};
      bw(sfcalu_pkg::OFS_SRC, rw.src, 2'h0);
      bw(sfcalu_pkg::OFS_XER, {29'h0, rw.x0}, 2'h0);
      bw(sfcalu_pkg::OFS_CR0, 32'ha, 2'h0);
      bw(sfcalu_pkg::OFS_INSTR, ins, 2'h0);
      chk(result_out, rw.res);
      chk({29'h0, xer_out}, {29'h0, rw.x});
      chk({28'h0, cr0_out}, {28'h0, rw.c});
      chk({27'h0, target_reg_index_out}, {27'h0, t});
      br_(sfcalu_pkg::OFS_INDEX, {19'h0, s, 3'h0, t}, 2'h0);
    end
    br_(sfcalu_pkg::OFS_IRQ_ST, 32'h3, 2'h0);
    bw(sfcalu_pkg::OFS_IRQ_EN, 32'h2, 2'h0);
    chk({31'h0, irq_out}, 32'h1);
    bw(sfcalu_pkg::OFS_IRQ_EN, 32'h4, 2'h0);
    chk({31'h0, irq_out}, 32'h0);
    bw(sfcalu_pkg::OFS_IRQ_CLR, 32'h3, 2'h0);
    br_(sfcalu_pkg::OFS_IRQ_ST, 32'h0, 2'h0);
    bw(sfcalu_pkg::OFS_INSTR, 32'h0, 2'h0);
    chk({31'h0, irq_out}, 32'h1);
    chk(result_out, rows[9].res);
    chk(32'(dones), 32'd10);
    br_(sfcalu_pkg::OFS_IRQ_ST, 32'h4, 2'h0);
    bw(6'h24, 32'h1, 2'h2);
    br_(6'h24, 32'h0, 2'h2);
    bw(sfcalu_pkg::OFS_RESULT, 32'h1, 2'h0);
    br_(sfcalu_pkg::OFS_RESULT, rows[9].res, 2'h0);
    @(posedge ref_clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    chk(result_out, 32'h0);
    chk({25'h0, xer_out, cr0_out}, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    nrst_in <= 1'b1;
    br_(sfcalu_pkg::OFS_IRQ_EN, 32'h0, 2'h0);
    final_report();
  end
endmodule
